//--- verilog/rlc_relay_cond.sv
`timescale 1ns/1ps
`include "rlc_defines.svh"
// How it works
// - selector offers relay-one sources plus extras
// - rise waits for assertion delay, 0..60000
// - delay forced zero for protective sources
// - fall waits for release hold, 0..9999
// - hold forced zero for protective sources
// - polarity picks relay level, high default
// - polarity locked high for protective sources
// - fallback off unless source is unassigned
// - fallback: command bit, error disables relay
// - no fallback: error keeps relay state
// - hold and polarity still apply on error
module rlc_relay_cond import rlc_pkg::*; #(
  parameter int unsigned TICK_CYC = `RLC_TICK_CYC,  // clocks per ms
  parameter int          NSRC     = 64,             // status source lines
  parameter int          CMD_BIT  = 1               // command word bit used
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // drive status, same clock
  input  wire logic [NSRC-1:0] status_src,
  input  wire logic            error_detect,
  // relay coil drive
  output logic             second_relay_output
);
  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [5:0]  src_r;        // source selector
  logic        pol_r;        // 1 = low-active
  logic        fb_r;         // fallback_enable
  logic [15:0] delay_r;      // assert_delay in ms
  logic [15:0] hold_r;       // release_hold in ms
  logic [15:0] cmd_r;        // logic_output_command_word
  logic        last_in_r;    // last filter input, held on error
  logic        wait_r;       // waitrequest flop
  logic [31:0] rdata_r;      // read data flop
  logic        relay_r;      // coil level flop

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) res[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return res;
  endfunction : be_merge

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  // each access stalls one cycle; the write lands when wait is low
  wire        wr_go   = avs_write && !wait_r;
  wire        sel_cfg = (avs_address == `RLC_OFS_CFG);
  wire        sel_dly = (avs_address == `RLC_OFS_DELAY);
  wire        sel_hld = (avs_address == `RLC_OFS_HOLD);
  wire        sel_cmd = (avs_address == `RLC_OFS_CMD);
  wire        sel_sts = (avs_address == `RLC_OFS_STATUS);

  // current register words, used for merging and reading
  wire [31:0] cfg_word = {22'h000000, fb_r, pol_r, 2'h0, src_r};
  wire [31:0] dly_word = {16'h0000, delay_r};
  wire [31:0] hld_word = {16'h0000, hold_r};
  wire [31:0] cmd_word = {16'h0000, cmd_r};

  // merged write words
  wire [31:0] cfg_wm = be_merge(cfg_word, avs_writedata, avs_byteenable);
  wire [31:0] dly_wm = be_merge(dly_word, avs_writedata, avs_byteenable);
  wire [31:0] hld_wm = be_merge(hld_word, avs_writedata, avs_byteenable);
  wire [31:0] cmd_wm = be_merge(cmd_word, avs_writedata, avs_byteenable);

  // ------------------------------------------------------------
  // source selection and forcing
  // ------------------------------------------------------------
  // new selector takes effect with its own write
  wire [5:0] src_nxt = (wr_go && sel_cfg)
                       ? cfg_wm[`RLC_CFG_SRC_MSB:`RLC_CFG_SRC_LSB] : src_r;
  wire       unassigned = (src_nxt == RLC_SRC_NONE);

  // protective sources pin the timing to zero
  wire       force_dly = (src_nxt == RLC_SRC_FLT_FREE) || (src_nxt == RLC_SRC_BRAKE)
                      || (src_nxt == RLC_SRC_OUTCONT)  || (src_nxt == RLC_SRC_MAINS);
  wire       force_hld = (src_nxt == RLC_SRC_FLT_FREE) || (src_nxt == RLC_SRC_BRAKE)
                      || (src_nxt == RLC_SRC_MAINS);
  // polarity lock includes bus charged but not output contactor
  wire       pol_lock  = (src_nxt == RLC_SRC_FLT_FREE) || (src_nxt == RLC_SRC_BRAKE)
                      || (src_nxt == RLC_SRC_BUS_CHG)  || (src_nxt == RLC_SRC_MAINS);

  // values written over the bus, saturated at their ranges
  wire [15:0] dly_sat = (dly_wm[15:0] > `RLC_DELAY_MAX) ? `RLC_DELAY_MAX : dly_wm[15:0];
  wire [15:0] hld_sat = (hld_wm[15:0] > `RLC_HOLD_MAX) ? `RLC_HOLD_MAX : hld_wm[15:0];

  // next register values, forcing wins over any write
  wire [15:0] delay_nxt = force_dly ? 16'h0000
                        : (wr_go && sel_dly) ? dly_sat : delay_r;
  wire [15:0] hold_nxt  = force_hld ? 16'h0000
                        : (wr_go && sel_hld) ? hld_sat : hold_r;
  wire        pol_nxt   = pol_lock ? 1'b0
                        : (wr_go && sel_cfg) ? cfg_wm[`RLC_CFG_POL_BIT] : pol_r;
  wire        fb_nxt    = !unassigned ? 1'b0
                        : (wr_go && sel_cfg) ? cfg_wm[`RLC_CFG_FB_BIT] : fb_r;

  // ------------------------------------------------------------
  // filter input selection
  // ------------------------------------------------------------
  // every code indexes a status line; extended codes are wired up too
  wire        src_lvl = status_src[src_r];
  wire        cmd_lvl = cmd_r[CMD_BIT];
  // unassigned relay: command bit, or on error 0 / held last value
  wire        unas_lvl = !error_detect ? cmd_lvl
                       : fb_r ? 1'b0
                       : last_in_r;
  // error feeds the filter, so hold and polarity still act
  wire        filt_in  = (src_r == RLC_SRC_NONE) ? unas_lvl : src_lvl;
  wire        filt_out;
  wire        filt_busy;
  wire        ms_tick;

  // ------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------
  rlc_tick #(
    .CYC (TICK_CYC)
  ) u_tick (
    .clock (clock),
    .rst   (rst),
    .tick  (ms_tick)
  );

  rlc_filter #(
    .DW (16)
  ) u_filter (
    .clock    (clock),
    .rst      (rst),
    .tick     (ms_tick),
    .delay_ms (delay_r),
    .hold_ms  (hold_r),
    .in_lvl   (filt_in),
    .out_lvl  (filt_out),
    .busy     (filt_busy)
  );

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  // status shows live state; unmapped words read zero
  wire [31:0] sts_word = {27'h0000000, error_detect, filt_busy,
                          filt_in, filt_out, relay_r};
  wire [31:0] rd_mux = sel_cfg ? cfg_word
                     : sel_dly ? dly_word
                     : sel_hld ? hld_word
                     : sel_cmd ? cmd_word
                     : sel_sts ? sts_word
                     : 32'h00000000;

  // ------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------
  // wait drops for one cycle per request, read data ready then
  always_ff @(posedge clock) begin
    if (rst) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h00000000;
    end else begin
      wait_r <= !((avs_read || avs_write) && wait_r);
      if (avs_read && wait_r) rdata_r <= rd_mux;
    end
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      src_r   <= `RLC_SRC_RST;       // drive running
      pol_r   <= 1'b0;               // high-active
      fb_r    <= 1'b0;               // fallback off
      delay_r <= `RLC_DELAY_RST;
      hold_r  <= `RLC_HOLD_RST;
      cmd_r   <= 16'h0000;
    end else begin
      src_r   <= src_nxt;
      pol_r   <= pol_nxt;
      fb_r    <= fb_nxt;
      delay_r <= delay_nxt;
      hold_r  <= hold_nxt;
      if (wr_go && sel_cmd) cmd_r <= cmd_wm[15:0];
    end
  end

  // ------------------------------------------------------------
  // output stage
  // ------------------------------------------------------------
  // polarity after the filter, so timing is on the source sense
  always_ff @(posedge clock) begin
    if (rst) begin
      last_in_r <= 1'b0;
      relay_r   <= 1'b0;
    end else begin
      last_in_r <= filt_in;
      relay_r   <= filt_out ^ pol_r;
    end
  end

  assign avs_waitrequest     = wait_r;
  assign avs_readdata        = rdata_r;
  assign second_relay_output = relay_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_default_source: assert property (
    $fell(rst) |-> (src_r == `RLC_SRC_RST) && !fb_r && !pol_r)
    else $error("wrong reset source");
  chk_polarity_map: assert property (
    ##1 (second_relay_output == ($past(filt_out) ^ $past(pol_r))))
    else $error("relay level not filter xor polarity");
  chk_delay_forced: assert property (
    (src_r == RLC_SRC_OUTCONT || src_r == RLC_SRC_BRAKE) |-> (delay_r == 16'h0000))
    else $error("delay not held at zero");
  chk_hold_forced: assert property (
    (src_r == RLC_SRC_MAINS || src_r == RLC_SRC_FLT_FREE) |-> (hold_r == 16'h0000))
    else $error("hold not held at zero");
  chk_pol_locked: assert property (
    (src_r == RLC_SRC_BUS_CHG) |-> !pol_r)
    else $error("polarity not locked high");
  chk_fallback_forced: assert property (
    (src_r != RLC_SRC_NONE) |-> !fb_r)
    else $error("fallback set with assigned source");
  chk_fallback_off: assert property (
    (src_r == RLC_SRC_NONE && fb_r && error_detect) |-> !filt_in)
    else $error("fallback did not disable");
  chk_keep_state: assert property (
    (src_r == RLC_SRC_NONE && !fb_r && error_detect) |-> (filt_in == last_in_r))
    else $error("relay input changed during error");
  chk_delay_range: assert property (
    (delay_r <= `RLC_DELAY_MAX) && (hold_r <= `RLC_HOLD_MAX))
    else $error("timing out of range");
  chk_wait_pulse: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low two cycles");

  cov_relay_rise: cover property ($rose(second_relay_output));
  cov_fb_error: cover property (src_r == RLC_SRC_NONE && fb_r && error_detect);
  cov_delayed_on: cover property ($rose(filt_in) && delay_r != 16'h0000);
endmodule : rlc_relay_cond

//--- verilog/rlc_defines.svh
`ifndef RLC_DEFINES_SVH
`define RLC_DEFINES_SVH
// ------------------------------------------------------------
// register byte offsets (one aligned 32-bit word each)
// ------------------------------------------------------------
`define RLC_OFS_CFG      8'h00
`define RLC_OFS_DELAY    8'h04
`define RLC_OFS_HOLD     8'h08
`define RLC_OFS_CMD      8'h0C
`define RLC_OFS_STATUS   8'h10
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define RLC_CFG_SRC_LSB  0
`define RLC_CFG_SRC_MSB  5
`define RLC_CFG_POL_BIT  8
`define RLC_CFG_FB_BIT   9
// ------------------------------------------------------------
// source selector codes
// ------------------------------------------------------------
`define RLC_SRC_NONE     6'h00
`define RLC_SRC_FLT_FREE 6'h01
`define RLC_SRC_RUNNING  6'h02
`define RLC_SRC_BUS_CHG  6'h03
`define RLC_SRC_BRAKE    6'h04
`define RLC_SRC_MAINS    6'h05
`define RLC_SRC_OUTCONT  6'h06
`define RLC_SRC_SPOOL    6'h07
`define RLC_SRC_WOBBLE   6'h08
// ------------------------------------------------------------
// reset values and limits
// ------------------------------------------------------------
`define RLC_SRC_RST      `RLC_SRC_RUNNING
`define RLC_DELAY_RST    16'h0000
`define RLC_HOLD_RST     16'h0000
`define RLC_DELAY_MAX    16'hEA60
`define RLC_HOLD_MAX     16'h270F
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define RLC_MS_NS        1000000
`define RLC_CLK_NS       10
`define RLC_TICK_CYC     (`RLC_MS_NS / `RLC_CLK_NS)
`endif

//--- verilog/rlc_pkg.sv
`include "rlc_defines.svh"
package rlc_pkg;
  // selector codes that steer forcing rules
  typedef enum logic [5:0] {
    RLC_SRC_NONE     = `RLC_SRC_NONE,
    RLC_SRC_FLT_FREE = `RLC_SRC_FLT_FREE,
    RLC_SRC_RUNNING  = `RLC_SRC_RUNNING,
    RLC_SRC_BUS_CHG  = `RLC_SRC_BUS_CHG,
    RLC_SRC_BRAKE    = `RLC_SRC_BRAKE,
    RLC_SRC_MAINS    = `RLC_SRC_MAINS,
    RLC_SRC_OUTCONT  = `RLC_SRC_OUTCONT,
    RLC_SRC_SPOOL    = `RLC_SRC_SPOOL,
    RLC_SRC_WOBBLE   = `RLC_SRC_WOBBLE
  } rlc_src_t;
  // filter states, gray along lo -> on -> hi -> off -> lo
  typedef enum logic [1:0] {
    RLC_ST_LO  = 2'h0,
    RLC_ST_ON  = 2'h1,
    RLC_ST_HI  = 2'h3,
    RLC_ST_OFF = 2'h2
  } rlc_state_t;
endpackage : rlc_pkg

//--- verilog/rlc_tick.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// millisecond enable divider
// ------------------------------------------------------------
module rlc_tick import rlc_pkg::*; #(
  parameter int unsigned CYC = 100000
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // one-cycle enable every CYC clocks
  output logic      tick
);
  localparam int CW = $clog2(CYC);
  logic [CW-1:0] cnt_r;  // free running divider
  wire           wrap = (cnt_r == CW'(CYC - 1));

  // divider and pulse
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_r <= wrap ? '0 : cnt_r + 1'b1;
      tick  <= wrap;
    end
  end
endmodule : rlc_tick

//--- verilog/rlc_filter.sv
`timescale 1ns/1ps
`include "rlc_defines.svh"
// ------------------------------------------------------------
// assertion delay / release hold filter
// ------------------------------------------------------------
module rlc_filter import rlc_pkg::*; #(
  parameter int DW = 16
) (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // timing
  input  wire logic          tick,
  input  wire logic [DW-1:0] delay_ms,
  input  wire logic [DW-1:0] hold_ms,
  // level in and out
  input  wire logic          in_lvl,
  output logic               out_lvl,
  output logic               busy
);
  rlc_state_t    state_r, state_nxt;  // filter state
  logic [DW-1:0] cnt_r, cnt_nxt;      // elapsed ms ticks

  // limit of the running wait; counting to limit+1 ticks is never early
  wire [DW-1:0] limit = (state_r == RLC_ST_ON) ? delay_ms : hold_ms;
  wire          done  = tick && (cnt_r == limit);

  // next state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      RLC_ST_LO: begin
        cnt_nxt = '0;
        if (in_lvl) state_nxt = (delay_ms == '0) ? RLC_ST_HI : RLC_ST_ON;
      end
      RLC_ST_ON: begin
        if (!in_lvl) state_nxt = RLC_ST_LO;          // pending rise dropped
        else if (done) state_nxt = RLC_ST_HI;
        else if (tick) cnt_nxt = cnt_r + 1'b1;
      end
      RLC_ST_HI: begin
        cnt_nxt = '0;
        if (!in_lvl) state_nxt = (hold_ms == '0) ? RLC_ST_LO : RLC_ST_OFF;
      end
      RLC_ST_OFF: begin
        if (in_lvl) state_nxt = RLC_ST_HI;           // pending fall dropped
        else if (done) state_nxt = RLC_ST_LO;
        else if (tick) cnt_nxt = cnt_r + 1'b1;
      end
      default: begin
        state_nxt = RLC_ST_LO;
        cnt_nxt   = '0;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= RLC_ST_LO;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= (state_nxt != state_r) ? '0 : cnt_nxt;
    end
  end

  assign out_lvl = (state_r == RLC_ST_HI) || (state_r == RLC_ST_OFF);
  assign busy    = (state_r == RLC_ST_ON) || (state_r == RLC_ST_OFF);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_no_early_on: assert property (
    (state_r == RLC_ST_LO && in_lvl && delay_ms != '0) |=> !out_lvl)
    else $error("relay rose before delay");
  chk_zero_delay: assert property (
    (state_r == RLC_ST_LO && in_lvl && delay_ms == '0) |=> out_lvl)
    else $error("zero delay not immediate");
  chk_hold_time: assert property (
    (state_r == RLC_ST_HI && !in_lvl && hold_ms != '0) |=> out_lvl)
    else $error("relay fell before hold");
  chk_cancel_pend: assert property (
    (state_r == RLC_ST_ON && !in_lvl) |=> (state_r == RLC_ST_LO) && !out_lvl)
    else $error("pending rise not cancelled");
  cov_cancel: cover property (state_r == RLC_ST_ON ##1 state_r == RLC_ST_LO);
endmodule : rlc_filter

//--- dv/rlc_coil_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// relay coil and contact model
// ------------------------------------------------------------
module rlc_coil_model #(
  parameter int unsigned SETTLE = 3  // armature travel in clocks
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // coil drive from the conditioner
  input  wire logic coil_drive,
  // contact seen by the load circuit
  output logic      contact_closed
);
  logic [SETTLE-1:0] arm_r;  // armature position history

  // armature lags the coil, so a glitch shorter than SETTLE still shows
  always_ff @(posedge clock) begin
    if (rst) begin
      arm_r <= '0;
    end else begin
      arm_r <= {arm_r[SETTLE-2:0], coil_drive};
    end
  end

  // contact closes once the armature has travelled
  assign contact_closed = arm_r[SETTLE-1];
endmodule : rlc_coil_model

//--- dv/rlc_relay_cond_bench.sv
`timescale 1ns/1ps
`include "rlc_defines.svh"
// ------------------------------------------------------------
// self-checking bench for the relay conditioner
// ------------------------------------------------------------
module rlc_relay_cond_bench import rlc_pkg::*; ;
  localparam int TK = 10;        // clocks per ms in this run
  logic        clock;            // system clock
  logic        rst;              // synchronous reset
  logic [7:0]  avs_address;      // bus address
  logic        avs_read;         // read request
  logic        avs_write;        // write request
  logic [31:0] avs_writedata;    // write data
  logic [3:0]  avs_byteenable;   // lanes, all on
  logic [31:0] avs_readdata;     // read data
  logic        avs_waitrequest;  // slave stall
  logic [63:0] status_src;       // drive status lines
  logic        error_detect;     // error level
  logic        second_relay_output; // coil drive
  logic        contact_closed;   // load contact
  int          n_errors;         // mismatches
  int          cmp_count;        // comparisons
  logic [31:0] rd;               // scratch read data
  rlc_src_t    tbl [7];          // selectable sources
  logic [5:0]  sc;               // source under test

  rlc_relay_cond #(.TICK_CYC(TK)) dut (
    .clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .status_src(status_src),
    .error_detect(error_detect), .second_relay_output(second_relay_output));

  rlc_coil_model #(.SETTLE(3)) coil (
    .clock(clock), .rst(rst), .coil_drive(second_relay_output),
    .contact_closed(contact_closed));

  // ------------------------------------------------------------
  // clock and watchdog
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // whole run needs well under a thousand clocks
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // one bus access; waitrequest and readdata are taken at the rising
  // edge, where the request still stands, and released only after it
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int   n;
    logic w;
    n = 0;
    w = 1'b1;
    q = 32'h0000_0000;
    @(posedge clock);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    while (w && n < 50) begin
      @(posedge clock);
      w = avs_waitrequest;
      q = avs_readdata;
      n++;
    end
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (w) begin
      n_errors++;
      $display("[FAIL] %0t bus access never answered", $time);
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0000_0000, rd);
    chk(rd, exp, what);
  endtask : rdc

  task automatic set_line(input int idx, input logic v);
    @(posedge clock);
    status_src[idx] <= v;
  endtask : set_line

  task automatic set_err(input logic v);
    @(posedge clock);
    error_detect <= v;
  endtask : set_err

  // relay must reach lvl no sooner than lo and no later than hi clocks
  task automatic wait_relay(input logic lvl, input int lo, input int hi, input string what);
    int n;
    n = 0;
    @(negedge clock);
    while (second_relay_output !== lvl && n <= hi) begin
      @(negedge clock);
      n++;
    end
    cmp_count++;
    if (n < lo || n > hi) begin
      n_errors++;
      $display("[FAIL] %0t %s: took %0d clocks, window %0d..%0d", $time, what, n, lo, hi);
    end
  endtask : wait_relay

  // relay must sit at lvl for cyc clocks
  task automatic steady(input logic lvl, input int cyc, input string what);
    logic ok;
    ok = 1'b1;
    repeat (cyc) begin
      @(negedge clock);
      if (second_relay_output !== lvl) ok = 1'b0;
    end
    chk({31'h0, ok}, 32'h0000_0001, what);
  endtask : steady

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    status_src = 64'h0;
    error_detect = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    tbl = '{RLC_SRC_FLT_FREE, RLC_SRC_BUS_CHG, RLC_SRC_BRAKE, RLC_SRC_MAINS,
            RLC_SRC_OUTCONT, RLC_SRC_SPOOL, RLC_SRC_WOBBLE};
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    // defaults and an unmapped word
    rdc(`RLC_OFS_CFG, 32'h0000_0002, "cfg default");
    rdc(`RLC_OFS_DELAY, 32'h0000_0000, "delay default");
    rdc(`RLC_OFS_HOLD, 32'h0000_0000, "hold default");
    wr(8'h14, 32'hFFFF_FFFF);
    rdc(8'h14, 32'h0000_0000, "unmapped read");
    $display("test defaults finished");
    // delay, hold and cancelled changes on the running source
    wr(`RLC_OFS_DELAY, 32'h0000_0003);
    wr(`RLC_OFS_HOLD, 32'h0000_0002);
    set_line(2, 1'b1);
    wait_relay(1'b1, 3 * TK, 4 * TK + 4, "rise after delay");
    set_line(2, 1'b0);
    wait_relay(1'b0, 2 * TK, 3 * TK + 4, "fall after hold");
    set_line(2, 1'b1);
    repeat (15) @(posedge clock);
    set_line(2, 1'b0);
    steady(1'b0, 6 * TK, "short pulse dropped");
    set_line(2, 1'b1);
    wait_relay(1'b1, 3 * TK, 4 * TK + 4, "rise again");
    set_line(2, 1'b0);
    repeat (10) @(posedge clock);
    set_line(2, 1'b1);
    steady(1'b1, 5 * TK, "short gap dropped");
    set_line(2, 1'b0);
    $display("test timing finished");
    // limits saturate
    wr(`RLC_OFS_DELAY, 32'h0000_FFFF);
    rdc(`RLC_OFS_DELAY, 32'h0000_EA60, "delay limit");
    wr(`RLC_OFS_HOLD, 32'h0000_FFFF);
    rdc(`RLC_OFS_HOLD, 32'h0000_270F, "hold limit");
    wr(`RLC_OFS_DELAY, 32'h0000_0000);
    wr(`RLC_OFS_HOLD, 32'h0000_0000);
    // low-active polarity
    wr(`RLC_OFS_CFG, 32'h0000_0102);
    wait_relay(1'b1, 0, TK + 4, "low active idle");
    set_line(2, 1'b1);
    wait_relay(1'b0, 0, TK + 4, "low active true");
    set_line(2, 1'b0);
    $display("test polarity finished");
    // forced fields per source, fallback bit always refused
    foreach (tbl[i]) begin
      sc = tbl[i];
      wr(`RLC_OFS_CFG, {22'h0, 4'hC, sc});
      wr(`RLC_OFS_DELAY, 32'h0000_0005);
      wr(`RLC_OFS_HOLD, 32'h0000_0005);
      rdc(`RLC_OFS_CFG, {22'h0, 1'b0, !(tbl[i] inside {RLC_SRC_FLT_FREE, RLC_SRC_BRAKE,
          RLC_SRC_BUS_CHG, RLC_SRC_MAINS}), 2'b00, sc}, "cfg forcing");
      rdc(`RLC_OFS_DELAY, (tbl[i] inside {RLC_SRC_FLT_FREE, RLC_SRC_BRAKE, RLC_SRC_MAINS,
          RLC_SRC_OUTCONT}) ? 32'h0 : 32'h5, "delay forcing");
      rdc(`RLC_OFS_HOLD, (tbl[i] inside {RLC_SRC_FLT_FREE, RLC_SRC_BRAKE, RLC_SRC_MAINS})
          ? 32'h0 : 32'h5, "hold forcing");
    end
    $display("test forcing finished");
    // fallback enabled: command bit, error releases through hold and polarity
    wr(`RLC_OFS_CFG, 32'h0000_0200);
    rdc(`RLC_OFS_CFG, 32'h0000_0200, "fallback set");
    wr(`RLC_OFS_DELAY, 32'h0000_0000);
    wr(`RLC_OFS_HOLD, 32'h0000_0002);
    wr(`RLC_OFS_CMD, 32'h0000_0002);
    wait_relay(1'b1, 0, TK + 4, "command bit on");
    set_err(1'b1);
    wait_relay(1'b0, 2 * TK, 3 * TK + 4, "error disables");
    set_err(1'b0);
    wait_relay(1'b1, 0, TK + 4, "error gone");
    wr(`RLC_OFS_CFG, 32'h0000_0300);
    wait_relay(1'b0, 0, TK + 4, "fallback low active");
    set_err(1'b1);
    wait_relay(1'b1, 2 * TK, 3 * TK + 4, "disable through polarity");
    set_err(1'b0);
    $display("test fallback finished");
    // fallback disabled: error keeps state, assigned relay still follows
    wr(`RLC_OFS_CFG, 32'h0000_0000);
    wr(`RLC_OFS_HOLD, 32'h0000_0000);
    wait_relay(1'b1, 0, TK + 4, "command drives relay");
    set_err(1'b1);
    wr(`RLC_OFS_CMD, 32'h0000_0000);
    steady(1'b1, 4 * TK, "error keeps relay");
    set_err(1'b0);
    wait_relay(1'b0, 0, TK + 4, "command resumes");
    wr(`RLC_OFS_CFG, 32'h0000_0002);
    set_err(1'b1);
    set_line(2, 1'b1);
    wait_relay(1'b1, 0, TK + 4, "assigned ignores error");
    repeat (5) @(posedge clock);
    chk({31'h0, contact_closed}, {31'h0, second_relay_output}, "contact follows coil");
    rdc(`RLC_OFS_STATUS, 32'h0000_0017, "status word");
    rdc(`RLC_OFS_CMD, 32'h0000_0000, "command word");
    $display("test hold on error finished");
    stop_test();
  end
endmodule : rlc_relay_cond_bench
